// [rtl/irtx_map.svh]
// Register offsets, field positions, reset values and sizes of the infrared engine
`ifndef IRTX_MAP_SVH
`define IRTX_MAP_SVH

// Register byte offsets
`define IRTX_OFS_CTRL        8'h00
`define IRTX_OFS_CARRIER     8'h04
`define IRTX_OFS_COMP        8'h08
`define IRTX_OFS_THRESH      8'h0C
`define IRTX_OFS_TX_PORT     8'h10
`define IRTX_OFS_RX_DATA     8'h14
`define IRTX_OFS_STATUS      8'h18
`define IRTX_OFS_CMD         8'h1C
`define IRTX_OFS_RX_LIMIT    8'h20
`define IRTX_OFS_RX_SAMPLE   8'h24

// Control register fields
`define IRTX_CTRL_TX_EN      0
`define IRTX_CTRL_RX_EN      1
`define IRTX_CTRL_CNT_SEL    2
`define IRTX_CTRL_TRIG_LO    4
`define IRTX_CTRL_TRIG_HI    5

// Command register fields (write-only pulses)
`define IRTX_CMD_CLR_TX      0
`define IRTX_CMD_CLR_RX      1
`define IRTX_CMD_MAN_TRIG    2

// Status register fields
`define IRTX_ST_TX_DONE      0
`define IRTX_ST_TX_FULL      1
`define IRTX_ST_RX_EMPTY     2
`define IRTX_ST_RX_FULL      3
`define IRTX_ST_TX_THR       4
`define IRTX_ST_RX_THR       5
`define IRTX_ST_CNT_THR      6
`define IRTX_ST_TX_RUN       7

// Transmit symbol word fields
`define IRTX_SYM_CARRIER     31
`define IRTX_SYM_COMP_HI     29
`define IRTX_SYM_COMP_LO     28
`define IRTX_SYM_CNT_W       28

// Receive entry and limit
`define IRTX_RX_LEVEL        31
`define IRTX_LIMIT_W         27
`define IRTX_LIMIT_RESET     27'h7FFFFFF

// Reset values
`define IRTX_CARRIER_RESET   32'h0002_0006
`define IRTX_COMP_RESET      16'h0001
`define IRTX_SAMPLE_RESET    16'h0001
`define IRTX_THRESH_RESET    16'h0000

`endif

// [rtl/irtx_pkg.sv]
// Types shared by the infrared engine modules
package irtx_pkg;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_LOAD = 3'b010,
        TX_RUN  = 3'b100
    } irtx_tx_state_t;

    typedef enum logic [1:0] {
        RX_WAIT = 2'b01,
        RX_RUN  = 2'b10
    } irtx_rx_state_t;

    typedef enum logic [1:0] {
        TRIG_FALL   = 2'b00,
        TRIG_RISE   = 2'b01,
        TRIG_EITHER = 2'b10,
        TRIG_MANUAL = 2'b11
    } irtx_trig_t;

    typedef enum logic [1:0] {
        COMP_NONE   = 2'b00,
        COMP_HALF   = 2'b01,
        COMP_DOUBLE = 2'b10,
        COMP_CLOCK  = 2'b11
    } irtx_comp_t;

endpackage

// [rtl/irtx_mem_if.sv]
// Write and read port bundle between a queue controller and its storage
`timescale 1ns/1ps
`default_nettype none
interface irtx_mem_if #(
    parameter int AW = 5,
    parameter int DW = 32
);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic          rd_en;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;

    modport ram  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
    modport user (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
endinterface
`default_nettype wire

// [rtl/irtx_fifo_mem.sv]
// Queue storage with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module irtx_fifo_mem #(
    parameter int AW = 5,
    parameter int DW = 32
) (
    // Clock
    input wire logic hclk,
    // Ports
    irtx_mem_if.ram  mem
);
    logic [DW-1:0] store [0:(1<<AW)-1];

    always_ff @(posedge hclk) begin
        if (mem.wr_en) begin
            store[mem.wr_addr] <= mem.wr_data;
        end
    end

    always_ff @(posedge hclk) begin
        if (mem.rd_en) begin
            mem.rd_data <= store[mem.rd_addr];
        end
    end
endmodule
`default_nettype wire

// [rtl/irtx_engine.sv]
// Infrared transmit and receive engine with symbol queues and an AHB-Lite register slave
//
// Summary of operation
// - Tx word bits 29:28 select gap timing
// - Selector 0 times gaps in carrier periods
// - Selector 3 times gaps in compensation periods
// - Selectors 1 and 2 give other timings
// - Carrier symbols always use carrier periods
// - Tx empty flag shows all data sent
// - Queue holds words until enabled; append anytime
// - Receiver settings programmable before enable
// - Rx queue threshold flag signals readable entries
// - Software command clears the receive queue
// - Level count limit reached on the cnt_sel level raises flag
// - Tx flag when depth at/below threshold
// - Rx flag when depth above threshold
`include "irtx_map.svh"
`timescale 1ns/1ps
`default_nettype none
module irtx_engine
    import irtx_pkg::*;
#(
    parameter int DEPTH = 32
) (
    // AHB-Lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Infrared pins
    input  wire logic        ir_rx_in,
    output logic             ir_tx_out,
    // Event flags
    output logic             tx_level_irq,
    output logic             rx_level_irq,
    output logic             rx_level_count_irq
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("DEPTH must be a power of two from 2 to 256");
        end
    endgenerate

    irtx_mem_if #(.AW(AW), .DW(32)) tx_mem ();
    irtx_mem_if #(.AW(AW), .DW(32)) rx_mem ();

    irtx_fifo_mem #(.AW(AW), .DW(32)) u_tx_mem (.hclk(hclk), .mem(tx_mem));
    irtx_fifo_mem #(.AW(AW), .DW(32)) u_rx_mem (.hclk(hclk), .mem(rx_mem));

    // Software-visible state
    logic [5:0]                ctrl;
    logic [15:0]               car_period;
    logic [15:0]               car_high;
    logic [15:0]               comp_div;
    logic [7:0]                tx_thr;
    logic [7:0]                rx_thr;
    logic [`IRTX_LIMIT_W-1:0]  cnt_limit;
    logic [15:0]               samp_div;
    logic                      cnt_thr_flag;

    // Bus phase tracking
    logic       wr_pend;
    logic       rd_pend;
    logic [7:0] addr_q;

    wire        addr_ok   = hsel && htrans[1] && hready;
    wire        rd_accept = addr_ok && !hwrite;
    wire        wr_accept = addr_ok && hwrite;
    wire [7:0]  ofs       = haddr[7:0];
    wire        wr_now    = wr_pend && hready;
    wire        wr_ctrl   = wr_now && addr_q == `IRTX_OFS_CTRL;
    wire        wr_car    = wr_now && addr_q == `IRTX_OFS_CARRIER;
    wire        wr_comp   = wr_now && addr_q == `IRTX_OFS_COMP;
    wire        wr_thr    = wr_now && addr_q == `IRTX_OFS_THRESH;
    wire        wr_port   = wr_now && addr_q == `IRTX_OFS_TX_PORT;
    wire        wr_status = wr_now && addr_q == `IRTX_OFS_STATUS;
    wire        wr_cmd    = wr_now && addr_q == `IRTX_OFS_CMD;
    wire        wr_limit  = wr_now && addr_q == `IRTX_OFS_RX_LIMIT;
    wire        wr_samp   = wr_now && addr_q == `IRTX_OFS_RX_SAMPLE;
    wire        clr_tx    = wr_cmd && hwdata[`IRTX_CMD_CLR_TX];
    wire        clr_rx    = wr_cmd && hwdata[`IRTX_CMD_CLR_RX];
    wire        man_trig  = wr_cmd && hwdata[`IRTX_CMD_MAN_TRIG];

    wire        tx_en     = ctrl[`IRTX_CTRL_TX_EN];
    wire        rx_en     = ctrl[`IRTX_CTRL_RX_EN];
    wire        cnt_sel   = ctrl[`IRTX_CTRL_CNT_SEL];
    wire irtx_trig_t trig = irtx_trig_t'(ctrl[`IRTX_CTRL_TRIG_HI:`IRTX_CTRL_TRIG_LO]);

    // Queue pointers
    logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
    logic [AW:0]   tx_cnt, rx_cnt;
    wire           tx_full  = tx_cnt == (AW+1)'(DEPTH);
    wire           tx_empty = tx_cnt == '0;
    wire           rx_full  = rx_cnt == (AW+1)'(DEPTH);
    wire           rx_empty = rx_cnt == '0;
    wire           tx_push  = wr_port && !tx_full;
    wire           rx_pop   = rd_accept && ofs == `IRTX_OFS_RX_DATA && !rx_empty;
    logic          tx_pop;
    logic          rx_push;
    logic [31:0]   rx_entry;

    assign tx_mem.wr_en   = tx_push;
    assign tx_mem.wr_addr = tx_wp;
    assign tx_mem.wr_data = hwdata;
    assign tx_mem.rd_en   = tx_pop;
    assign tx_mem.rd_addr = tx_rp;
    assign rx_mem.wr_en   = rx_push && !rx_full && !clr_rx;
    assign rx_mem.wr_addr = rx_wp;
    assign rx_mem.wr_data = rx_entry;
    assign rx_mem.rd_en   = rx_pop;
    assign rx_mem.rd_addr = rx_rp;

    wire [AW:0] next_tx_cnt = clr_tx ? '0 : tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    wire [AW:0] next_rx_cnt = clr_rx ? '0 : rx_cnt + (AW+1)'(rx_push && !rx_full) - (AW+1)'(rx_pop);

    // Transmit timing
    irtx_tx_state_t            tx_state;
    logic [`IRTX_SYM_CNT_W-1:0] sym_left;
    logic                      sym_carrier;
    irtx_comp_t                sym_comp;
    logic [15:0]               car_cnt;
    logic [15:0]               comp_cnt;
    logic                      comp_phase;

    wire car_tick   = car_cnt == car_period - 16'h0001;
    wire half_tick  = car_tick || car_cnt == (car_period >> 1) - 16'h0001;
    wire comp_tick  = comp_cnt == comp_div - 16'h0001;
    wire comp2_tick = comp_tick && comp_phase;
    logic unit_tick;
    always_comb begin
        unit_tick = car_tick;
        if (!sym_carrier) begin
            case (sym_comp)
                COMP_HALF:   unit_tick = half_tick;
                COMP_DOUBLE: unit_tick = comp2_tick;
                COMP_CLOCK:  unit_tick = comp_tick;
                default:     unit_tick = car_tick;
            endcase
        end
    end

    wire sym_end      = tx_state == TX_RUN && sym_left == '0;
    wire fetch        = tx_en && !tx_empty && !clr_tx;
    assign tx_pop     = fetch && (tx_state == TX_IDLE || sym_end);
    wire next_tx_pin  = tx_state == TX_RUN && sym_left != '0 && sym_carrier && car_cnt < car_high;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_state <= TX_IDLE;
        end else if (tx_pop) begin
            tx_state <= TX_LOAD;
        end else if (tx_state == TX_LOAD) begin
            tx_state <= TX_RUN;
        end else if (sym_end) begin
            tx_state <= TX_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sym_left    <= '0;
            sym_carrier <= 1'b0;
            sym_comp    <= COMP_NONE;
            car_cnt     <= '0;
            comp_cnt    <= '0;
            comp_phase  <= 1'b0;
        end else if (tx_state == TX_LOAD) begin
            sym_left    <= tx_mem.rd_data[`IRTX_SYM_CNT_W-1:0] & 28'h0FFFFFF;
            sym_carrier <= tx_mem.rd_data[`IRTX_SYM_CARRIER];
            sym_comp    <= irtx_comp_t'(tx_mem.rd_data[`IRTX_SYM_COMP_HI:`IRTX_SYM_COMP_LO]);
            car_cnt     <= '0;
            comp_cnt    <= '0;
            comp_phase  <= 1'b0;
        end else if (tx_state == TX_RUN) begin
            car_cnt    <= car_tick ? '0 : car_cnt + 16'h0001;
            comp_cnt   <= comp_tick ? '0 : comp_cnt + 16'h0001;
            comp_phase <= comp_phase ^ comp_tick;
            if (unit_tick && sym_left != '0) begin
                sym_left <= sym_left - 1'b1;
            end
        end
    end

    // Receive sampling
    irtx_rx_state_t            rx_state;
    logic [15:0]               samp_cnt;
    logic                      rx_prev;
    logic                      run_level;
    logic [`IRTX_LIMIT_W-1:0]  level_cnt;

    wire samp_tick   = rx_en && samp_cnt == samp_div - 16'h0001;
    wire edge_seen   = ir_rx_in != rx_prev;
    wire trig_hit    = (trig == TRIG_FALL && rx_prev && !ir_rx_in)
                    || (trig == TRIG_RISE && !rx_prev && ir_rx_in)
                    || (trig == TRIG_EITHER && edge_seen);
    wire start_run   = rx_state == RX_WAIT && rx_en
                    && ((samp_tick && trig_hit) || (trig == TRIG_MANUAL && man_trig));
    wire run_tick    = rx_state == RX_RUN && samp_tick;
    wire level_next  = run_tick && !edge_seen;
    wire [`IRTX_LIMIT_W-1:0] next_level_cnt = level_cnt + 1'b1;
    wire limit_hit   = level_next && run_level == cnt_sel && next_level_cnt >= cnt_limit;
    assign rx_push   = (run_tick && edge_seen) || limit_hit;
    assign rx_entry  = {run_level, 4'h0, limit_hit ? next_level_cnt : level_cnt};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            samp_cnt <= '0;
            rx_prev  <= 1'b1;
        end else if (!rx_en) begin
            samp_cnt <= '0;
            rx_prev  <= ir_rx_in;
        end else if (samp_tick) begin
            samp_cnt <= '0;
            rx_prev  <= ir_rx_in;
        end else begin
            samp_cnt <= samp_cnt + 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_state  <= RX_WAIT;
            run_level <= 1'b0;
            level_cnt <= '0;
        end else if (!rx_en || limit_hit) begin
            rx_state  <= RX_WAIT;
        end else if (start_run) begin
            rx_state  <= RX_RUN;
            run_level <= ir_rx_in;
            level_cnt <= `IRTX_LIMIT_W'(1);
        end else if (run_tick && edge_seen) begin
            run_level <= ir_rx_in;
            level_cnt <= `IRTX_LIMIT_W'(1);
        end else if (level_next && level_cnt != '1) begin
            level_cnt <= next_level_cnt;
        end
    end

    // Queue bookkeeping
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_wp  <= '0;
            tx_rp  <= '0;
            tx_cnt <= '0;
            rx_wp  <= '0;
            rx_rp  <= '0;
            rx_cnt <= '0;
        end else begin
            tx_cnt <= next_tx_cnt;
            rx_cnt <= next_rx_cnt;
            tx_wp  <= clr_tx ? tx_rp : tx_wp + AW'(tx_push);
            tx_rp  <= tx_rp + AW'(tx_pop);
            rx_wp  <= clr_rx ? '0 : rx_wp + AW'(rx_push && !rx_full);
            rx_rp  <= clr_rx ? '0 : rx_rp + AW'(rx_pop);
        end
    end

    // Status and event flags
    wire tx_done      = tx_empty && tx_state == TX_IDLE;
    wire tx_thr_hit   = 9'(tx_cnt) <= {1'b0, tx_thr};
    wire rx_thr_hit   = 9'(rx_cnt) > {1'b0, rx_thr};
    wire [31:0] status = {8'h00, 8'(rx_cnt), 8'(tx_cnt),
                          tx_state != TX_IDLE, cnt_thr_flag, rx_thr_hit, tx_thr_hit,
                          rx_full, rx_empty, tx_full, tx_done};

    // Register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl         <= '0;
            {car_high, car_period} <= `IRTX_CARRIER_RESET;
            comp_div     <= `IRTX_COMP_RESET;
            {rx_thr, tx_thr} <= `IRTX_THRESH_RESET;
            cnt_limit    <= `IRTX_LIMIT_RESET;
            samp_div     <= `IRTX_SAMPLE_RESET;
            cnt_thr_flag <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl <= hwdata[5:0];
            if (wr_car) {car_high, car_period} <= hwdata;
            if (wr_comp) comp_div <= hwdata[15:0];
            if (wr_thr) {rx_thr, tx_thr} <= hwdata[15:0];
            if (wr_limit) cnt_limit <= hwdata[`IRTX_LIMIT_W-1:0];
            if (wr_samp) samp_div <= hwdata[15:0];
            if (limit_hit) begin
                cnt_thr_flag <= 1'b1;
            end else if (wr_status && hwdata[`IRTX_ST_CNT_THR]) begin
                cnt_thr_flag <= 1'b0;
            end
        end
    end

    // Read data selection
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (addr_q == `IRTX_OFS_CTRL) rd_mux = {26'h0, ctrl};
        else if (addr_q == `IRTX_OFS_CARRIER) rd_mux = {car_high, car_period};
        else if (addr_q == `IRTX_OFS_COMP) rd_mux = {16'h0, comp_div};
        else if (addr_q == `IRTX_OFS_THRESH) rd_mux = {16'h0, rx_thr, tx_thr};
        else if (addr_q == `IRTX_OFS_RX_DATA) rd_mux = rx_mem.rd_data;
        else if (addr_q == `IRTX_OFS_STATUS) rd_mux = status;
        else if (addr_q == `IRTX_OFS_RX_LIMIT) rd_mux = {5'h0, cnt_limit};
        else if (addr_q == `IRTX_OFS_RX_SAMPLE) rd_mux = {16'h0, samp_div};
    end

    // Bus handshake: writes finish with no wait, reads add one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            addr_q    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= '0;
        end else begin
            if (hready) begin
                wr_pend <= wr_accept;
                if (addr_ok) addr_q <= {ofs[7:2], 2'b00};
            end
            rd_pend   <= rd_accept;
            hreadyout <= !rd_accept;
            hresp     <= 1'b0;
            if (rd_pend) hrdata <= rd_mux;
        end
    end

    // Pin and flag outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ir_tx_out          <= 1'b0;
            tx_level_irq       <= 1'b0;
            rx_level_irq       <= 1'b0;
            rx_level_count_irq <= 1'b0;
        end else begin
            ir_tx_out          <= next_tx_pin;
            tx_level_irq       <= tx_thr_hit;
            rx_level_irq       <= rx_thr_hit;
            rx_level_count_irq <= cnt_thr_flag;
        end
    end
endmodule
`default_nettype wire

// [tb/irtx_engine_checker.sv]
// Bus, transmit and receive timing checks on the infrared engine's ports
`include "irtx_map.svh"
`timescale 1ns/1ps
`default_nettype none
module irtx_engine_checker #(
    parameter int DEPTH = 32
) (
    // Bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Pins and flags
    input wire logic        ir_tx_out,
    input wire logic        tx_level_irq,
    input wire logic        rx_level_irq,
    input wire logic        rx_level_count_irq
);
    logic        ph_v;
    logic        ph_w;
    logic [7:0]  ph_a;
    logic        tx_en;
    logic [15:0] car_high;
    logic [15:0] hi_run;
    logic [1:0]  st_hist;
    wire         take = hsel & htrans[1] & hready;
    wire         wr_now = ph_v & ph_w & hready;
    wire         clr_rx = wr_now & (ph_a == `IRTX_OFS_CMD) & hwdata[`IRTX_CMD_CLR_RX];
    wire         st_clr = wr_now & (ph_a == `IRTX_OFS_STATUS) & hwdata[`IRTX_ST_CNT_THR];

    // Shadow of the address phase and of the fields the checks depend on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_v     <= 1'b0;
            ph_w     <= 1'b0;
            ph_a     <= 8'h00;
            tx_en    <= 1'b0;
            car_high <= 16'h0002;
            hi_run   <= 16'h0000;
            st_hist  <= 2'h0;
        end else begin
            if (hready) begin
                ph_v <= take;
                ph_w <= hwrite;
                ph_a <= haddr[7:0];
            end
            if (wr_now && ph_a == `IRTX_OFS_CTRL) tx_en <= hwdata[`IRTX_CTRL_TX_EN];
            if (wr_now && ph_a == `IRTX_OFS_CARRIER) car_high <= hwdata[31:16];
            hi_run  <= ir_tx_out ? hi_run + 16'h0001 : 16'h0000;
            st_hist <= {st_hist[0], st_clr};
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    okay_resp_a: assert property (hresp == 1'b0) else $error("response not OKAY");
    read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    write_ready_a: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
    wait_once_a: assert property (!hreadyout |=> hreadyout) else $error("wait state too long");
    tx_hold_a: assert property ($rose(ir_tx_out) |-> tx_en) else $error("transmit while disabled");
    carrier_high_a: assert property ($fell(ir_tx_out) |-> hi_run == car_high) else $error("carrier high time wrong");
    rx_clear_a: assert property (clr_rx |-> ##[1:2] !rx_level_irq) else $error("rx queue not cleared");
    tx_thr_reset_a: assert property ($rose(hresetn) |-> ##[1:2] tx_level_irq) else $error("tx threshold flag off");
    cnt_sticky_a: assert property ($fell(rx_level_count_irq) |-> |st_hist) else $error("level flag lost");

    read_c: cover property (take && !hwrite);
    tx_c: cover property ($rose(ir_tx_out));
    cnt_c: cover property ($rose(rx_level_count_irq));
    clr_c: cover property (clr_rx);
endmodule
bind irtx_engine irtx_engine_checker #(.DEPTH(DEPTH)) chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .ir_tx_out(ir_tx_out), .tx_level_irq(tx_level_irq), .rx_level_irq(rx_level_irq),
    .rx_level_count_irq(rx_level_count_irq));
`default_nettype wire

// [tb/irtx_ir_model.sv]
// Emitter pulse recorder and receiver waveform source
`timescale 1ns/1ps
`default_nettype none
module irtx_ir_model (
    // Clock
    input  wire logic hclk,
    // Emitter side
    input  wire logic ir_tx_out,
    // Receiver side
    input  wire logic rx_go,
    output logic      ir_rx_in
);
    int   rises = 0;
    int   low_cnt = 0;
    int   low_run [16];
    logic last = 1'b0;

    // Low time before each rising edge of the LED drive
    always @(posedge hclk) begin
        if (ir_tx_out && !last) begin
            low_run[rises % 16] = low_cnt;
            rises = rises + 1;
        end
        low_cnt = ir_tx_out ? 0 : low_cnt + 1;
        last = ir_tx_out;
    end

    // Idle high, then low 41, high 41, low 40 and a long high
    initial begin
        ir_rx_in = 1'b1;
        @(posedge rx_go);
        for (int i = 0; i < 3; i++) begin
            @(posedge hclk);
            ir_rx_in <= i[0];
            repeat (40) @(posedge hclk);
        end
        ir_rx_in <= 1'b1;
    end
endmodule
`default_nettype wire

// [tb/infrared_tx_rx_fifo_engine_test.sv]
// Register level test of the infrared engine
`include "irtx_map.svh"
`timescale 1ns/1ps
`default_nettype none
module infrared_tx_rx_fifo_engine_test;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        rx_go = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        ir_rx_in;
    logic        ir_tx_out;
    logic        tx_level_irq;
    logic        rx_level_irq;
    logic        rx_level_count_irq;
    logic [31:0] rd;
    int          fails = 0;
    int          num_checks = 0;
    logic [7:0]  ra [8] = '{`IRTX_OFS_CTRL, `IRTX_OFS_CARRIER, `IRTX_OFS_COMP, `IRTX_OFS_THRESH,
                            `IRTX_OFS_RX_LIMIT, `IRTX_OFS_RX_SAMPLE, 8'h30, 8'h3C};
    logic [31:0] re [8] = '{32'h0, `IRTX_CARRIER_RESET, {16'h0, `IRTX_COMP_RESET}, 32'h0,
                            {5'h0, `IRTX_LIMIT_RESET}, {16'h0, `IRTX_SAMPLE_RESET}, 32'h0, 32'h0};
    // Gaps of each selector between single carrier periods
    logic [31:0] sym [8] = '{32'h8000_0001, 32'h0000_0002, 32'hB000_0001, 32'h3000_0002,
                             32'h8000_0001, 32'h1000_0002, 32'h8000_0001, 32'h2000_0002};

    always #2 hclk = ~hclk;

    irtx_engine #(.DEPTH(32)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ir_rx_in(ir_rx_in), .ir_tx_out(ir_tx_out),
        .tx_level_irq(tx_level_irq), .rx_level_irq(rx_level_irq), .rx_level_count_irq(rx_level_count_irq));
    irtx_ir_model model_u (.hclk(hclk), .ir_tx_out(ir_tx_out), .rx_go(rx_go), .ir_rx_in(ir_rx_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) fails++;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #40000;
        fails++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 8; i++) rdchk(ra[i], re[i]);
        rdchk(`IRTX_OFS_STATUS, 32'h0000_0015);
        // Queue while disabled, then enable and append
        wr(`IRTX_OFS_COMP, 32'h0000_0009);
        wr(`IRTX_OFS_THRESH, 32'h0000_0102);
        for (int i = 0; i < 8; i++) wr(`IRTX_OFS_TX_PORT, sym[i]);
        repeat (40) @(posedge hclk);
        rdchk(`IRTX_OFS_STATUS, 32'h0000_0804);
        check(32'(model_u.rises), 32'h0);
        check(32'(tx_level_irq), 32'h0);
        wr(`IRTX_OFS_CTRL, 32'h0000_0001);
        wr(`IRTX_OFS_TX_PORT, 32'hB000_0002);
        for (int n = 0; n < 200; n++) begin
            bus(1'b0, `IRTX_OFS_STATUS, 32'h0);
            if (rd[`IRTX_ST_TX_DONE] === 1'b1) break;
        end
        check(32'(model_u.rises), 32'h6);
        check(32'(tx_level_irq), 32'h1);
        check(32'(model_u.low_run[2] - model_u.low_run[1]), 32'h6);
        check(32'(model_u.low_run[3] - model_u.low_run[1]), 32'hFFFF_FFFA);
        check(32'(model_u.low_run[4] - model_u.low_run[1]), 32'h18);
        check(32'(model_u.low_run[5]), 32'h4);
        // Receive with the high phase ending the frame
        wr(`IRTX_OFS_RX_LIMIT, 32'h0000_0064);
        wr(`IRTX_OFS_CTRL, 32'h0000_0007);
        wr(`IRTX_OFS_CMD, 32'h0000_0002);
        rx_go <= 1'b1;
        for (int n = 0; n < 1000 && rx_level_count_irq !== 1'b1; n++) @(posedge hclk);
        rdchk(`IRTX_OFS_STATUS, 32'h0004_0071);
        check(32'(rx_level_irq), 32'h1);
        bus(1'b0, `IRTX_OFS_RX_DATA, 32'h0);
        check(32'(rd[`IRTX_RX_LEVEL]), 32'h0);
        bus(1'b0, `IRTX_OFS_RX_DATA, 32'h0);
        check(32'(rd[`IRTX_RX_LEVEL]), 32'h1);
        wr(`IRTX_OFS_CMD, 32'h0000_0002);
        rdchk(`IRTX_OFS_STATUS, 32'h0000_0055);
        check(32'(rx_level_irq), 32'h0);
        wr(`IRTX_OFS_STATUS, 32'h0000_0040);
        rdchk(`IRTX_OFS_STATUS, 32'h0000_0015);
        check(32'(rx_level_count_irq), 32'h0);
        // Manual trigger on a steady high level ends at the limit
        wr(`IRTX_OFS_CTRL, 32'h0000_0036);
        wr(`IRTX_OFS_CMD, 32'h0000_0004);
        repeat (110) @(posedge hclk);
        rdchk(`IRTX_OFS_RX_DATA, 32'h8000_0064);
        check(32'(rx_level_count_irq), 32'h1);
        final_report();
    end
endmodule
`default_nettype wire
